//--- design/apdc_pkg.sv
package apdc_pkg;
   // ==========================================================
   // Timing figures and derived cycle counts
   // ==========================================================
   localparam int unsigned CLK_PERIOD_PS     = 5000;
   localparam int unsigned INVALID_TIME_NS   = 30000;    // 30 us
   localparam int unsigned VALID_TIME_NS     = 1000;     // 1 us
   localparam int unsigned RECOVER_TIME_NS   = 100000;   // 100 us
   localparam int unsigned IDLE_TIME_S       = 30;       // 30 s
   // Least times round up, and all stay at least one cycle
   localparam int unsigned INVALID_CYCLES = (INVALID_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned VALID_CYCLES   = (VALID_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned RECOVER_CYCLES = (RECOVER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam longint unsigned IDLE_CYCLES =
      (longint'(IDLE_TIME_S) * 64'd1000000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Widths of the line groups
   localparam int unsigned NUM_TX  = 3;
   localparam int unsigned NUM_RX  = 5;

   // Power state of the line drivers
   typedef enum logic [1:0] {
      APDC_ACTIVE,
      APDC_WAKING,
      APDC_AUTO_DOWN,
      APDC_FORCED_DOWN
   } apdc_state_e;

   // Enables handed to the analog blocks
   typedef struct packed {
      logic pump_on;
      logic tx_enable;
      logic rx_enable;
      logic monitor_enable;
   } apdc_power_s;
endpackage

//--- design/apdc_timer.sv
// ==========================================================
// Restartable up counter: counts while restart_in is low and
// reports done once LIMIT cycles have passed without restart
// ==========================================================
module apdc_timer #(
   parameter int unsigned WIDTH = 16,
   parameter logic [WIDTH-1:0] LIMIT = '1
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic nrst_in,
   // Control
   input  wire logic restart_in,
   input  wire logic expire_in,
   // Status
   output logic      done_out
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;

   // Saturating count; expire forces the timed-out state
   always_comb
   begin
      next_count = count;
      if (restart_in)
         next_count = '0;
      else if (expire_in)
         next_count = LIMIT;
      else if (count != LIMIT)
         next_count = count + WIDTH'(1);
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         count <= '0;
      else
         count <= next_count;
   end

   assign done_out = (count == LIMIT);
endmodule

//--- design/apdc_top.sv
// What this block does
// - Signal-absent flag falls after invalid levels on all receivers beyond 30 us.
// - Signal-absent flag rises 1 us after any receiver shows valid level.
// - Signal-absent detection runs in every power state.
// - Signal-absent flag never alters power state by itself.
// - Thirty seconds without transitions powers down pump and transmitters.
// - Any input transition wakes the device from automatic powerdown.
// - Inactivity powerdown works only with force-active low, force-shutdown high.
// - Force-active high disables idle powerdown; force-shutdown low always powers down.
// - After any powerdown the idle timer stays expired until wake event.
// - Leaving automatic powerdown restores operation after about 100 us.
// - With flag on force-shutdown only, stay down after cable returns until a transition.
// - Inverting receivers off only in forced powerdown; monitor receiver always on.
// - After force-active falls, stay up 30 s without transitions.
module apdc_top #(
   parameter longint unsigned IDLE_LIMIT    = apdc_pkg::IDLE_CYCLES,
   parameter int unsigned     INVALID_LIMIT = apdc_pkg::INVALID_CYCLES,
   parameter int unsigned     VALID_LIMIT   = apdc_pkg::VALID_CYCLES,
   parameter int unsigned     RECOVER_LIMIT = apdc_pkg::RECOVER_CYCLES,
   parameter int unsigned     NUM_TX        = apdc_pkg::NUM_TX,
   parameter int unsigned     NUM_RX        = apdc_pkg::NUM_RX
) (
   // Clock and reset
   input  wire logic              CLK_SYS_IN,
   input  wire logic              NRST_IN,
   // Force controls
   input  wire logic              FORCE_ACTIVE_IN,
   input  wire logic              FORCE_SHUTDOWN_N_IN,
   // Line side activity and level detectors
   input  wire logic [NUM_TX-1:0] TX_DATA_IN,
   input  wire logic [NUM_RX-1:0] RX_DATA_IN,
   input  wire logic [NUM_RX-1:0] RX_LEVEL_VALID_IN,
   // Status and power enables
   output logic                   SIGNAL_VALID_N_OUT,
   output logic                   POWERED_DOWN_OUT,
   output logic                   READY_OUT,
   output apdc_pkg::apdc_power_s  POWER_OUT
);
   // ==========================================================
   // Transition detection on all data inputs
   // ==========================================================
   logic [NUM_TX+NUM_RX-1:0] data_prev;
   logic [NUM_TX+NUM_RX-1:0] next_data_prev;
   logic                     force_active_prev;
   logic                     next_force_active_prev;
   logic                     any_edge;
   logic                     force_active_fall;
   logic                     force_active_rise;

   // Samples start at reset value zero, so a high input at release counts as activity
   always_comb
   begin
      next_data_prev         = {TX_DATA_IN, RX_DATA_IN};
      next_force_active_prev = FORCE_ACTIVE_IN;
   end

   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         data_prev         <= '0;
         force_active_prev <= 1'b0;
      end
      else
      begin
         data_prev         <= next_data_prev;
         force_active_prev <= next_force_active_prev;
      end
   end

   assign any_edge          = |(data_prev ^ {TX_DATA_IN, RX_DATA_IN});
   assign force_active_fall = force_active_prev & ~FORCE_ACTIVE_IN;
   assign force_active_rise = ~force_active_prev & FORCE_ACTIVE_IN;

   // ==========================================================
   // Signal-absent detection, independent of power state
   // ==========================================================
   logic any_valid;
   logic invalid_done;
   logic valid_done;
   logic flag_high;
   logic next_flag_high;

   assign any_valid = |RX_LEVEL_VALID_IN;

   // Invalid time restarts whenever any receiver is valid
   apdc_timer #(
      .WIDTH ($clog2(INVALID_LIMIT + 1)),
      .LIMIT (($clog2(INVALID_LIMIT + 1))'(INVALID_LIMIT))
   ) u_invalid_timer (
      .clk_in     (CLK_SYS_IN),
      .nrst_in    (NRST_IN),
      .restart_in (any_valid),
      .expire_in  (1'b0),
      .done_out   (invalid_done)
   );

   // Valid time restarts whenever all receivers are invalid
   apdc_timer #(
      .WIDTH ($clog2(VALID_LIMIT + 1)),
      .LIMIT (($clog2(VALID_LIMIT + 1))'(VALID_LIMIT))
   ) u_valid_timer (
      .clk_in     (CLK_SYS_IN),
      .nrst_in    (NRST_IN),
      .restart_in (~any_valid),
      .expire_in  (1'b0),
      .done_out   (valid_done)
   );

   // Flag holds its level between the two thresholds
   always_comb
   begin
      next_flag_high = flag_high;
      if (valid_done)
         next_flag_high = 1'b1;
      else if (invalid_done)
         next_flag_high = 1'b0;
   end

   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
         flag_high <= 1'b0;
      else
         flag_high <= next_flag_high;
   end

   // Flag feeds only the pin, never the power logic
   assign SIGNAL_VALID_N_OUT = flag_high;

   // ==========================================================
   // Inactivity timer and power state
   // ==========================================================
   localparam int unsigned IDLE_W = $clog2(IDLE_LIMIT + 1);
   apdc_pkg::apdc_state_e state;
   apdc_pkg::apdc_state_e next_state;
   logic                  idle_done;
   logic                  idle_restart;
   logic                  idle_expire;
   logic                  auto_enabled;
   logic [$clog2(RECOVER_LIMIT+1)-1:0] wake_count;
   logic [$clog2(RECOVER_LIMIT+1)-1:0] next_wake_count;

   // Automatic mode only with force-active low and shutdown released
   assign auto_enabled = ~FORCE_ACTIVE_IN & FORCE_SHUTDOWN_N_IN;
   // Edges or force-active fall restart the 30 s window
   assign idle_restart = any_edge | force_active_fall;
   // Any powerdown leaves the timer expired
   assign idle_expire  = (state == apdc_pkg::APDC_AUTO_DOWN) |
                         (state == apdc_pkg::APDC_FORCED_DOWN);

   apdc_timer #(
      .WIDTH (IDLE_W),
      .LIMIT (IDLE_W'(IDLE_LIMIT))
   ) u_idle_timer (
      .clk_in     (CLK_SYS_IN),
      .nrst_in    (NRST_IN),
      .restart_in (idle_restart),
      .expire_in  (idle_expire),
      .done_out   (idle_done)
   );

   // Force-shutdown wins over everything; wake needs an edge or force-active high
   always_comb
   begin
      next_state      = state;
      next_wake_count = '0;
      if (!FORCE_SHUTDOWN_N_IN)
         next_state = apdc_pkg::APDC_FORCED_DOWN;
      else
      begin
         unique case (state)
            apdc_pkg::APDC_ACTIVE:
               if (auto_enabled && idle_done && !idle_restart)
                  next_state = apdc_pkg::APDC_AUTO_DOWN;
            apdc_pkg::APDC_WAKING:
               if (auto_enabled && idle_done && !idle_restart)
                  next_state = apdc_pkg::APDC_AUTO_DOWN;
               else if (wake_count == ($bits(wake_count))'(RECOVER_LIMIT - 1))
                  next_state = apdc_pkg::APDC_ACTIVE;
               else
                  next_wake_count = wake_count + ($bits(wake_count))'(1);
            apdc_pkg::APDC_AUTO_DOWN,
            apdc_pkg::APDC_FORCED_DOWN:
               if (any_edge || force_active_rise || FORCE_ACTIVE_IN)
                  next_state = apdc_pkg::APDC_WAKING;
               // Shutdown released with no wake event: timer stays expired, receivers come back
               else
                  next_state = apdc_pkg::APDC_AUTO_DOWN;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         state      <= apdc_pkg::APDC_WAKING;
         wake_count <= '0;
      end
      else
      begin
         state      <= next_state;
         wake_count <= next_wake_count;
      end
   end

   // ==========================================================
   // Power enables: receivers cut only in forced powerdown
   // ==========================================================
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         POWER_OUT        <= '{pump_on: 1'b1, tx_enable: 1'b0, rx_enable: 1'b1, monitor_enable: 1'b1};
         POWERED_DOWN_OUT <= 1'b0;
         READY_OUT        <= 1'b0;
      end
      else
      begin
         POWER_OUT.pump_on        <= (next_state == apdc_pkg::APDC_ACTIVE) |
                                     (next_state == apdc_pkg::APDC_WAKING);
         POWER_OUT.tx_enable      <= (next_state == apdc_pkg::APDC_ACTIVE);
         POWER_OUT.rx_enable      <= (next_state != apdc_pkg::APDC_FORCED_DOWN);
         POWER_OUT.monitor_enable <= 1'b1;
         POWERED_DOWN_OUT         <= (next_state == apdc_pkg::APDC_AUTO_DOWN) |
                                     (next_state == apdc_pkg::APDC_FORCED_DOWN);
         READY_OUT                <= (next_state == apdc_pkg::APDC_ACTIVE);
      end
   end
endmodule

//--- verif/apdc_pm_model.sv
// ==========================================================
// Board power management driving the two force inputs
// ==========================================================
module apdc_pm_model (
   // Strap choice: 0 manual, 1 flag on both, 2 flag on shutdown only
   input  wire logic [1:0] mode_in,
   input  wire logic       manual_active_in,
   input  wire logic       manual_shutdown_n_in,
   // Flag fed back from the device
   input  wire logic       signal_valid_n_in,
   // Force controls toward the device
   output logic            force_active_out,
   output logic            force_shutdown_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Plain wiring: a strapped flag reaches the pins with no delay of its own
   assign force_active_out     = (mode_in == 2'h1) ? signal_valid_n_in : manual_active_in;
   assign force_shutdown_n_out = (mode_in != 2'h0) ? signal_valid_n_in : manual_shutdown_n_in;
endmodule

//--- verif/apdc_assertions.sv
// ==========================================================
// Port level checks of the powerdown controller
// ==========================================================
module apdc_assertions #(
   parameter longint unsigned IDLE_LIMIT    = 200,
   parameter int unsigned     INVALID_LIMIT = 30,
   parameter int unsigned     VALID_LIMIT   = 5,
   parameter int unsigned     RECOVER_LIMIT = 10,
   parameter int unsigned     NUM_TX        = 3,
   parameter int unsigned     NUM_RX        = 5
) (
   // Clock, reset and force controls
   input wire logic                  CLK_SYS_IN,
   input wire logic                  NRST_IN,
   input wire logic                  FORCE_ACTIVE_IN,
   input wire logic                  FORCE_SHUTDOWN_N_IN,
   // Line side
   input wire logic [NUM_TX-1:0]     TX_DATA_IN,
   input wire logic [NUM_RX-1:0]     RX_DATA_IN,
   input wire logic [NUM_RX-1:0]     RX_LEVEL_VALID_IN,
   // Results
   input wire logic                  SIGNAL_VALID_N_OUT,
   input wire logic                  POWERED_DOWN_OUT,
   input wire logic                  READY_OUT,
   input wire apdc_pkg::apdc_power_s POWER_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned inv_cnt, val_cnt, wake_cnt, idle_cnt;
   // Last line sample; starts at zero like the device, so a high line at release counts as activity
   logic [NUM_TX+NUM_RX-1:0] line_last;
   // Run lengths of each cause; a test run is far too short for them to wrap
   always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         inv_cnt  <= 0;
         val_cnt  <= 0;
         wake_cnt <= 0;
         idle_cnt <= 0;
         line_last <= '0;
      end
      else
      begin
         inv_cnt  <= (|RX_LEVEL_VALID_IN) ? 0 : inv_cnt + 1;
         val_cnt  <= (|RX_LEVEL_VALID_IN) ? val_cnt + 1 : 0;
         wake_cnt <= (!POWERED_DOWN_OUT && !READY_OUT) ? wake_cnt + 1 : 0;
         line_last <= {TX_DATA_IN, RX_DATA_IN};
         idle_cnt <= ((line_last != {TX_DATA_IN, RX_DATA_IN}) || FORCE_ACTIVE_IN || !FORCE_SHUTDOWN_N_IN) ? 0 : idle_cnt + 1;
      end
   end
   default clocking @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (!NRST_IN);
   // Bounds carry one or two cycles of slack for the output registers
   a_forced_down: assert property (!FORCE_SHUTDOWN_N_IN |=> POWERED_DOWN_OUT && !POWER_OUT.rx_enable)
      else $error("shutdown input low but device not forced down");
   a_down_quiet: assert property (POWERED_DOWN_OUT |-> !POWER_OUT.pump_on && !POWER_OUT.tx_enable && !READY_OUT)
      else $error("pump or transmitters on while powered down");
   a_wake_edge: assert property (POWERED_DOWN_OUT && FORCE_SHUTDOWN_N_IN && $changed({TX_DATA_IN, RX_DATA_IN})
      |=> !POWERED_DOWN_OUT && POWER_OUT.pump_on) else $error("line edge did not wake the device");
   a_force_wake: assert property (FORCE_ACTIVE_IN && FORCE_SHUTDOWN_N_IN |=> !POWERED_DOWN_OUT)
      else $error("force-active high but device down");
   a_ready_time: assert property ($rose(READY_OUT) |-> wake_cnt + 1 >= RECOVER_LIMIT && wake_cnt <= RECOVER_LIMIT + 1)
      else $error("recovery time off");
   a_flag_fall: assert property ($fell(SIGNAL_VALID_N_OUT) |-> inv_cnt + 1 >= INVALID_LIMIT)
      else $error("flag fell too early");
   a_flag_low: assert property (inv_cnt > INVALID_LIMIT + 1 |-> !SIGNAL_VALID_N_OUT)
      else $error("flag still high after invalid time");
   a_flag_high: assert property (val_cnt > VALID_LIMIT + 1 |-> SIGNAL_VALID_N_OUT)
      else $error("flag still low after valid time");
   a_idle_down: assert property (idle_cnt > IDLE_LIMIT + 2 |-> POWERED_DOWN_OUT)
      else $error("no powerdown after idle time");
   a_monitor_on: assert property (POWER_OUT.monitor_enable)
      else $error("monitor receiver disabled");
   a_pump_up: assert property (!POWERED_DOWN_OUT |-> POWER_OUT.pump_on)
      else $error("pump off while not powered down");
   a_rx_auto_on: assert property (FORCE_SHUTDOWN_N_IN ##1 FORCE_SHUTDOWN_N_IN |-> POWER_OUT.rx_enable)
      else $error("receivers off although shutdown input is high");
endmodule
bind apdc_top apdc_assertions #(.IDLE_LIMIT(IDLE_LIMIT), .INVALID_LIMIT(INVALID_LIMIT), .VALID_LIMIT(VALID_LIMIT),
   .RECOVER_LIMIT(RECOVER_LIMIT), .NUM_TX(NUM_TX), .NUM_RX(NUM_RX)) u_apdc_assertions (.CLK_SYS_IN(CLK_SYS_IN),
   .NRST_IN(NRST_IN), .FORCE_ACTIVE_IN(FORCE_ACTIVE_IN), .FORCE_SHUTDOWN_N_IN(FORCE_SHUTDOWN_N_IN),
   .TX_DATA_IN(TX_DATA_IN), .RX_DATA_IN(RX_DATA_IN), .RX_LEVEL_VALID_IN(RX_LEVEL_VALID_IN),
   .SIGNAL_VALID_N_OUT(SIGNAL_VALID_N_OUT), .POWERED_DOWN_OUT(POWERED_DOWN_OUT), .READY_OUT(READY_OUT),
   .POWER_OUT(POWER_OUT));

//--- verif/test_auto_powerdown_control.sv
// ==========================================================
// Self-checking bench with shortened time limits
// ==========================================================
module test_auto_powerdown_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned IL = 200, INV = 30, VL = 5, RL = 10;
   logic                  clk = 1'b0, nrst = 1'b0, ma = 1'b1, ms = 1'b1, fa, fs, flag, pd, rdy;
   logic [1:0]            mode = 2'h0;
   logic [2:0]            tx = 3'h0;
   logic [4:0]            rx = 5'h00, lv = 5'h1f;
   apdc_pkg::apdc_power_s pwr;
   int                    fails = 0, num_checks = 0;
   // Rows: {force-active, force-shutdown_n}, cycles, expected {down, ready, flag, rx enable}
   logic [21:0]           rows [6] = '{{2'h3, 16'd220, 4'h7}, {2'h2, 16'd3, 4'ha}, {2'h0, 16'd3, 4'ha},
                                       {2'h3, 16'd15, 4'h7}, {2'h1, 16'd180, 4'h7}, {2'h1, 16'd40, 4'hb}};
   // 200 MHz clock
   always #2.5 clk = ~clk;
   apdc_top #(.IDLE_LIMIT(IL), .INVALID_LIMIT(INV), .VALID_LIMIT(VL), .RECOVER_LIMIT(RL)) dut (.CLK_SYS_IN(clk),
      .NRST_IN(nrst), .FORCE_ACTIVE_IN(fa), .FORCE_SHUTDOWN_N_IN(fs), .TX_DATA_IN(tx), .RX_DATA_IN(rx),
      .RX_LEVEL_VALID_IN(lv), .SIGNAL_VALID_N_OUT(flag), .POWERED_DOWN_OUT(pd), .READY_OUT(rdy), .POWER_OUT(pwr));
   apdc_pm_model pm (.mode_in(mode), .manual_active_in(ma), .manual_shutdown_n_in(ms), .signal_valid_n_in(flag),
      .force_active_out(fa), .force_shutdown_n_out(fs));
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Wait whole cycles, then compare the masked status once it has settled
   task automatic look(input int n, input logic [3:0] exp, input logic [3:0] mask);
      repeat (n) @(posedge clk);
      #1;
      chk({pd, rdy, flag, pwr.rx_enable} & mask, exp);
   endtask
   // Bounded wait for transmitters; a hang ends the run at once
   task automatic wait_ready;
      int i;
      i = 0;
      while (rdy !== 1'b1 && i < RL + VL + 10)
      begin
         @(posedge clk);
         #1;
         i++;
      end
      chk({3'h0, rdy}, 4'h1);
      if (rdy !== 1'b1)
         complete_run;
   endtask
   // Main sequence: table rows first, then the awkward cases
   initial
   begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      wait_ready;
      for (int r = 0; r < 6; r++)
      begin
         @(posedge clk);
         {ma, ms} <= rows[r][21:20];
         look(rows[r][19:4], rows[r][3:0], 4'hf);
      end
      @(posedge clk) tx <= 3'h4;
      look(2, 4'h0, 4'hc);
      wait_ready;
      @(posedge clk) lv <= 5'h00;
      ms <= 1'b0;
      look(INV - 5, 4'ha, 4'hf);
      look(10, 4'h8, 4'hf);
      @(posedge clk) lv <= 5'h04;
      look(VL + 3, 4'ha, 4'hf);
      @(posedge clk) mode <= 2'h2;
      look(20, 4'hb, 4'hf);
      @(posedge clk) rx <= 5'h01;
      wait_ready;
      @(posedge clk) lv <= 5'h00;
      look(INV + 5, 4'h8, 4'he);
      @(posedge clk) lv <= 5'h10;
      look(VL + 10, 4'hb, 4'hf);
      @(posedge clk) tx <= 3'h5;
      wait_ready;
      @(posedge clk) mode <= 2'h1;
      lv <= 5'h00;
      look(INV + 5, 4'h8, 4'hf);
      @(posedge clk) lv <= 5'h01;
      wait_ready;
      @(posedge clk) nrst <= 1'b0;
      mode <= 2'h0;
      ms <= 1'b1;
      // Shutdown released again, else the device would stay forced down after reset
      #1;
      chk({pd, rdy, flag, pwr.rx_enable}, 4'h1);
      @(posedge clk) nrst <= 1'b1;
      wait_ready;
      complete_run;
   end
endmodule
